//--- design/lpm_pkg.sv
`default_nettype none
package lpm_pkg;
   // ******
   // register map, byte offsets
   // ******
   localparam logic [7:0] OFS_SUPPLY_CTRL = 8'h00;
   localparam logic [7:0] OFS_MAIN_OSC    = 8'h04;
   localparam logic [7:0] OFS_FAST_START  = 8'h08;
   localparam logic [7:0] OFS_PM_STATUS   = 8'h0C;
   localparam logic [7:0] OFS_PERIPH_CLK  = 8'h10;
   localparam logic [7:0] OFS_BACKUP_WAKE = 8'h14;
   // ******
   // field positions
   // ******
   localparam int SC_REGOFF_BIT = 0;
   localparam int SC_REGDIS_BIT = 1;
   localparam int SC_KEY_LSB    = 24;
   localparam int MO_WAIT_BIT   = 0;
   localparam int MO_SRC_LSB    = 1;
   localparam int MO_RCF_LSB    = 4;
   localparam int MO_PRES_LSB   = 8;
   localparam int FS_RTC_BIT    = 16;
   localparam int FS_RTT_BIT    = 17;
   localparam int FS_USB_BIT    = 18;
   localparam int FS_LPM_BIT    = 20;
   localparam int FS_FLASH_LOW_POWER_SELECT_LSB   = 21;
   localparam int BW_SM_BIT     = 16;
   localparam int BW_RTC_BIT    = 17;
   localparam int BW_RTT_BIT    = 18;
   localparam int BW_DEB_BIT    = 20;
   localparam int ST_MASTER_CLOCK_READY_BIT = 0;
   localparam int ST_MODE_LSB   = 4;
   localparam int ST_REGON_BIT  = 8;
   // ******
   // reset values and codes
   // ******
   localparam logic [31:0] MO_RESET = 32'h0000_0000;
   localparam logic [31:0] FS_RESET = 32'h0000_0000;
   localparam logic [31:0] BW_RESET = 32'h0000_0000;
   // key value is arbitrary
   localparam logic [7:0] SC_KEY_DEF  = 8'hA5;
   localparam logic [1:0] SRC_FAST_RC = 2'h0;
   localparam logic [1:0] RCF_4MHZ    = 2'h0;
   localparam logic [1:0] FL_STANDBY  = 2'h0;
   localparam logic [1:0] FL_DEEP_PD  = 2'h1;
   localparam logic [1:0] FL_IDLE     = 2'h2;
   localparam logic [1:0] FL_ACTIVE   = 2'h3;
   // ******
   // timing
   // ******
   localparam int CLK_HZ         = 20_000_000;
   localparam int REG_START_US   = 300;
   localparam int REG_START_CYC  = REG_START_US * (CLK_HZ / 1_000_000);
   localparam int DEB_CYCLES_DEF = 16;
   // ******
   // types
   // ******
   typedef enum logic [2:0] {
      M_ACTIVE,
      M_SLEEP,
      M_WAIT,
      M_BACKUP,
      M_REG_START
   } lpm_mode_type;
   typedef struct packed {
      logic sm;
      logic rtc;
      logic real_time_timer;
      logic usb;
   } lpm_alarm_type;
   typedef struct packed {
      logic core_clk;
      logic mem_clk;
      logic core_power;
      logic regulator_on;
      logic reg_out_low;
   } lpm_pwr_type;
endpackage
`default_nettype wire

//--- design/lpm_wake_filter.sv
`default_nettype none
module lpm_wake_filter
   import lpm_pkg::*;
#(
   parameter int WIDTH      = 16,
   parameter int DEB_CYCLES = DEB_CYCLES_DEF
) (
   input  wire logic             clk_i,    // system clock
   input  wire logic             rst_i,    // sync reset
   input  wire logic [WIDTH-1:0] pins_i,   // wake-up pins
   input  wire logic [WIDTH-1:0] bk_en_i,  // backup wake enables
   input  wire logic [WIDTH-1:0] fs_en_i,  // fast startup enables
   input  wire logic             deb_en_i, // debounce on
   output logic                  toggle_o, // enabled pin changed
   output logic                  low_o     // enabled pin low
);
   localparam int CW = $clog2(DEB_CYCLES + 1);
   if (WIDTH < 1 || DEB_CYCLES < 1) begin : g_bad
      $error("lpm_wake_filter: bad parameters");
   end
   logic [WIDTH-1:0] toggled;
   logic             low;
   logic             next_low;
   // ******
   // per-pin debounce
   // ******
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      logic [CW-1:0] cnt;
      logic [CW-1:0] next_cnt;
      logic          st;
      logic          next_st;
      logic          tg;
      logic          next_tg;
      always_comb begin
         next_cnt = cnt;
         next_st  = st;
         next_tg  = 1'b0;
         if (pins_i[i] == st) begin
            next_cnt = '0;
         end else if (!deb_en_i || cnt == CW'(DEB_CYCLES - 1)) begin
            next_st  = pins_i[i];
            next_cnt = '0;
            next_tg  = bk_en_i[i]; // see R04
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cnt <= '0;
            st  <= 1'b1;
            tg  <= 1'b0;
         end else begin
            cnt <= next_cnt;
            st  <= next_st;
            tg  <= next_tg;
         end
      end
      assign toggled[i] = tg;
   end
   // fast startup takes the raw level: debounce would cost wake time
   always_comb begin
      next_low = |(~pins_i & fs_en_i); // see R06
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low <= 1'b0;
      end else begin
         low <= next_low;
      end
   end
   assign toggle_o = |toggled;
   assign low_o    = low;
endmodule
`default_nettype wire

//--- design/lpm_low_power_ctrl.sv
// What this block does
// R01: keyed regulator-off write enters Backup
// R02: deep-sleep plus wait-for-event enters Backup
// R03: backup domain runs; regulator, core off
// R04: enabled pin, monitor, clock, timer wake Backup
// R05: Wait stops core, peripheral, memory clocks
// R06: fast-startup pins, alarms, USB wake Wait
// R07: software prepares clocks before wait request
// R08: software polls master clock ready after Wait
// R09: software prepares clocks before wait-for-event
// R10: flash select: standby, deep, idle
// R11: Sleep stops core clock, peripherals stay
// R12: sleep instructions with low-power select zero
// R13: wake Sleep by interrupt or event
// R14: pending event flag blocks wait-for-event
// R15: software disables regulator apart from Backup
// R16: regulator output low; ready in 300 us
// R17: Active mode changes clock, gates peripherals
// R18: fast startup restarts fast RC at 4 MHz
// R19: Backup wake re-enables core supplies
// R20: wrong key ignored, mode unchanged
`default_nettype none
module lpm_low_power_ctrl
   import lpm_pkg::*;
#(
   parameter int         NPERIPH     = 32,
   parameter int         NPINS       = 16,
   parameter int         DEB_CYCLES  = DEB_CYCLES_DEF,
   parameter int         REG_START   = REG_START_CYC,
   parameter logic [7:0] SUPPLY_KEY  = SC_KEY_DEF
) (
   input  wire logic                clk_i,         // 20 MHz
   input  wire logic                rst_i,         // sync reset
   input  wire logic                wb_cyc_i,      // bus cycle
   input  wire logic                wb_stb_i,      // strobe
   input  wire logic                wb_we_i,       // write
   input  wire logic [7:0]          wb_adr_i,      // byte address
   input  wire logic [3:0]          wb_sel_i,      // byte enables
   input  wire logic [31:0]         wb_dat_i,      // write data
   output logic                     wb_ack_o,      // acknowledge
   output logic [31:0]              wb_dat_o,      // read data
   input  wire logic                wfi_i,         // wait-for-interrupt
   input  wire logic                wfe_i,         // wait-for-event
   input  wire logic                deep_sleep_select_i, // core bit
   input  wire logic                event_flag_i,  // core event flag
   input  wire logic                irq_i,         // any interrupt
   input  wire logic                event_i,       // core event
   input  wire logic [NPINS-1:0]    wakeup_pins_i, // wake pins
   input  wire lpm_alarm_type       alarm_i,       // alarm sources
   output lpm_pwr_type              pwr_o,         // power, clocks
   output logic [NPERIPH-1:0]       periph_clk_en_o, // gated clks
   output logic [1:0]               flash_mode_o,  // flash state
   output logic [1:0]               mck_src_o,     // clock source
   output logic [1:0]               rc_freq_o,     // fast RC select
   output logic [2:0]               clk_pres_o,    // prescaler
   output logic                     fast_rc_en_o,  // fast RC on
   output logic                     core_reset_o,  // core reset
   output logic                     backup_on_o,   // backup domain
   output logic [2:0]               mode_o         // current mode
);
   if (NPERIPH < 1 || NPERIPH > 32 || NPINS != 16 || REG_START < 1)
   begin : g_bad
      $error("lpm_low_power_ctrl: bad parameters");
   end
   localparam int RCW = $clog2(REG_START + 1);

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      hit = (adr[7:2] == ofs[7:2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wr,
                                         input logic [3:0]  sel);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merge[8*b +: 8] = wr[8*b +: 8];
         end
      end
   endfunction

   // ******
   // bus slave and plain registers
   // ******
   logic               ack;
   logic               next_ack;
   logic [31:0]        dat;
   logic [31:0]        next_dat;
   logic [31:0]        fs;
   logic [31:0]        next_fs;
   logic [31:0]        bw;
   logic [31:0]        next_bw;
   logic [NPERIPH-1:0] pc;
   logic [NPERIPH-1:0] next_pc;
   logic               req;
   logic               wr;
   logic               sc_ok;
   logic [31:0]        mo_wdat;

   lpm_mode_type       mode;
   lpm_mode_type       next_mode;
   logic [31:0]        mo;
   logic [31:0]        next_mo;
   logic               reg_dis;
   logic               next_reg_dis;
   logic               wfi_entry;
   logic               next_wfi_entry;
   logic               mck_rdy;
   logic               next_mck_rdy;
   logic [RCW-1:0]     cnt;
   logic [RCW-1:0]     next_cnt;

   assign req     = wb_cyc_i && wb_stb_i && !ack;
   assign wr      = req && wb_we_i;
   // the key counts only with the control byte
   assign sc_ok   = wr && hit(wb_adr_i, OFS_SUPPLY_CTRL) && wb_sel_i[3]
                    && wb_sel_i[0]
                    && wb_dat_i[SC_KEY_LSB +: 8] == SUPPLY_KEY; // see R20
   assign mo_wdat = merge(mo, wb_dat_i, wb_sel_i);

   always_comb begin
      next_ack = req;
      next_dat = dat;
      next_fs  = fs;
      next_bw  = bw;
      next_pc  = pc;
      if (req && !wb_we_i) begin
         next_dat = 32'h0000_0000;
         if (hit(wb_adr_i, OFS_SUPPLY_CTRL)) begin
            next_dat[SC_REGDIS_BIT] = reg_dis;
         end else if (hit(wb_adr_i, OFS_MAIN_OSC)) begin
            next_dat = mo;
         end else if (hit(wb_adr_i, OFS_FAST_START)) begin
            next_dat = fs;
         end else if (hit(wb_adr_i, OFS_PM_STATUS)) begin
            next_dat[ST_MASTER_CLOCK_READY_BIT] = mck_rdy; // see R08
            next_dat[ST_MODE_LSB +: 3] = mode;
            next_dat[ST_REGON_BIT] = pwr_o.regulator_on;
         end else if (hit(wb_adr_i, OFS_PERIPH_CLK)) begin
            next_dat[NPERIPH-1:0] = pc;
         end else if (hit(wb_adr_i, OFS_BACKUP_WAKE)) begin
            next_dat = bw;
         end
      end
      if (wr) begin
         if (hit(wb_adr_i, OFS_FAST_START)) begin
            next_fs = merge(fs, wb_dat_i, wb_sel_i);
         end else if (hit(wb_adr_i, OFS_PERIPH_CLK)) begin
            next_pc = NPERIPH'(merge(32'(pc), wb_dat_i, wb_sel_i)); // see R17
         end else if (hit(wb_adr_i, OFS_BACKUP_WAKE)) begin
            next_bw = merge(bw, wb_dat_i, wb_sel_i);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         dat <= 32'h0000_0000;
         fs  <= FS_RESET;
         bw  <= BW_RESET;
         pc  <= '0;
      end else begin
         ack <= next_ack;
         dat <= next_dat;
         fs  <= next_fs;
         bw  <= next_bw;
         pc  <= next_pc;
      end
   end

   // ******
   // wake-up sources
   // ******
   logic pin_toggle;
   logic pin_low;
   logic fs_wake;
   logic bk_wake;

   lpm_wake_filter #(
      .WIDTH      (NPINS),
      .DEB_CYCLES (DEB_CYCLES)
   ) u_wake (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .pins_i   (wakeup_pins_i),
      .bk_en_i  (bw[NPINS-1:0]),
      .fs_en_i  (fs[NPINS-1:0]),
      .deb_en_i (bw[BW_DEB_BIT]),
      .toggle_o (pin_toggle),
      .low_o    (pin_low)
   );

   assign fs_wake = pin_low
                    || (alarm_i.rtc && fs[FS_RTC_BIT])
                    || (alarm_i.real_time_timer && fs[FS_RTT_BIT])
                    || (alarm_i.usb && fs[FS_USB_BIT]); // see R06
   assign bk_wake = pin_toggle
                    || (alarm_i.sm  && bw[BW_SM_BIT])
                    || (alarm_i.rtc && bw[BW_RTC_BIT])
                    || (alarm_i.real_time_timer && bw[BW_RTT_BIT]); // see R04

   // ******
   // mode sequencer
   // ******
   lpm_pwr_type        next_pwr;
   logic [NPERIPH-1:0] next_pclk;
   logic [1:0]         next_flash;
   logic               lpm;
   logic               wfe_ok;

   assign lpm    = fs[FS_LPM_BIT];
   // a pending event makes the instruction fall straight through
   assign wfe_ok = wfe_i && !event_flag_i; // see R14

   always_comb begin
      next_mode      = mode;
      next_mo        = mo;
      next_reg_dis   = reg_dis;
      next_wfi_entry = wfi_entry;
      next_mck_rdy   = mck_rdy;
      next_cnt       = cnt;
      if (sc_ok) begin
         next_reg_dis = wb_dat_i[SC_REGDIS_BIT]; // see R15
      end
      if (wr && hit(wb_adr_i, OFS_MAIN_OSC)) begin
         next_mo = mo_wdat;
         next_mo[MO_WAIT_BIT] = 1'b0;
      end
      case (mode)
         M_ACTIVE: begin
            if (sc_ok && wb_dat_i[SC_REGOFF_BIT]) begin
               next_mode = M_BACKUP; // see R01
            end else if (wfe_ok && deep_sleep_select_i) begin
               next_mode = M_BACKUP; // see R02
            end else if (wr && hit(wb_adr_i, OFS_MAIN_OSC)
                         && mo_wdat[MO_WAIT_BIT]) begin
               next_mode    = M_WAIT;
               next_mck_rdy = 1'b0; // see R08
            end else if (wfe_ok && lpm) begin
               next_mode    = M_WAIT;
               next_mck_rdy = 1'b0;
            end else if (wfi_i && !deep_sleep_select_i && !lpm) begin
               next_mode      = M_SLEEP; // see R12
               next_wfi_entry = 1'b1;
            end else if (wfe_ok && !lpm) begin
               next_mode      = M_SLEEP; // see R12
               next_wfi_entry = 1'b0;
            end
         end
         M_SLEEP: begin
            if (wfi_entry ? irq_i : (irq_i || event_i || fs_wake)) begin
               next_mode = M_ACTIVE; // see R13
            end
         end
         M_WAIT: begin
            if (fs_wake) begin
               next_mode    = M_ACTIVE; // see R06
               next_mck_rdy = 1'b1;
               next_mo[MO_SRC_LSB +: 2] = SRC_FAST_RC; // see R18
               next_mo[MO_RCF_LSB +: 2] = RCF_4MHZ;
            end
         end
         M_BACKUP: begin
            if (bk_wake) begin
               next_mode = M_REG_START; // see R19
               next_cnt  = '0;
            end
         end
         M_REG_START: begin
            // core comes back through reset, so clock setup restarts too
            if (cnt == RCW'(REG_START - 1)) begin
               next_mode    = M_ACTIVE; // see R16
               next_mo      = MO_RESET;
               next_mck_rdy = 1'b1;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         default: begin
            next_mode = M_ACTIVE;
         end
      endcase

      next_pwr.core_clk     = (next_mode == M_ACTIVE); // see R05 R11
      next_pwr.mem_clk      = (next_mode == M_ACTIVE || next_mode == M_SLEEP);
      next_pwr.core_power   = (next_mode != M_BACKUP
                               && next_mode != M_REG_START); // see R03
      next_pwr.regulator_on = (next_mode != M_BACKUP) && !next_reg_dis;
      next_pwr.reg_out_low  = (next_mode == M_BACKUP); // see R16
      next_pclk = (next_mode == M_ACTIVE || next_mode == M_SLEEP)
                  ? next_pc : '0; // see R11 R17
      next_flash = FL_ACTIVE;
      if (next_mode == M_WAIT) begin
         case (next_fs[FS_FLASH_LOW_POWER_SELECT_LSB +: 2])
            FL_DEEP_PD: next_flash = FL_DEEP_PD; // see R10
            FL_IDLE:    next_flash = FL_IDLE;
            default:    next_flash = FL_STANDBY;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode            <= M_ACTIVE;
         mo              <= MO_RESET;
         reg_dis         <= 1'b0;
         wfi_entry       <= 1'b0;
         mck_rdy         <= 1'b1;
         cnt             <= '0;
         pwr_o           <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
         periph_clk_en_o <= '0;
         flash_mode_o    <= FL_ACTIVE;
         mck_src_o       <= MO_RESET[MO_SRC_LSB +: 2];
         rc_freq_o       <= MO_RESET[MO_RCF_LSB +: 2];
         clk_pres_o      <= MO_RESET[MO_PRES_LSB +: 3];
         fast_rc_en_o    <= 1'b1;
         core_reset_o    <= 1'b0;
         backup_on_o     <= 1'b1;
         mode_o          <= 3'h0;
      end else begin
         mode            <= next_mode;
         mo              <= next_mo;
         reg_dis         <= next_reg_dis;
         wfi_entry       <= next_wfi_entry;
         mck_rdy         <= next_mck_rdy;
         cnt             <= next_cnt;
         pwr_o           <= next_pwr;
         periph_clk_en_o <= next_pclk;
         flash_mode_o    <= next_flash;
         mck_src_o       <= next_mo[MO_SRC_LSB +: 2]; // see R17
         rc_freq_o       <= next_mo[MO_RCF_LSB +: 2];
         clk_pres_o      <= next_mo[MO_PRES_LSB +: 3];
         fast_rc_en_o    <= (next_mode == M_ACTIVE || next_mode == M_SLEEP)
                            && next_mo[MO_SRC_LSB +: 2] == SRC_FAST_RC;
         core_reset_o    <= (next_mode == M_BACKUP
                             || next_mode == M_REG_START);
         backup_on_o     <= 1'b1; // see R03
         mode_o          <= next_mode;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = dat;
endmodule
`default_nettype wire

//--- testbench/lpm_core_model.sv
`default_nettype none
module lpm_core_model
   import lpm_pkg::*;
(
   input  wire logic    clk_i,   // clock
   output logic         wfi_o,   // wfi pulse
   output logic         wfe_o,   // wfe pulse
   output logic         deep_o,  // deep-sleep select
   output logic         flag_o,  // event flag
   output logic         irq_o,   // interrupt level
   output logic         event_o, // core event
   output logic [15:0]  pins_o,  // wake pins, idle high
   output lpm_alarm_type alarm_o // alarm sources
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {wfi_o, wfe_o, deep_o, flag_o, irq_o, event_o, alarm_o} = '0;
      pins_o = 16'hFFFF;
   end
   // deep and flag are held by the bench, as the core would
   task automatic instr(input logic use_wfe);
      @(posedge clk_i);
      if (use_wfe) begin
         wfe_o <= 1'h1;
      end else begin
         wfi_o <= 1'h1;
      end
      @(posedge clk_i);
      wfe_o <= 1'h0;
      wfi_o <= 1'h0;
   endtask
endmodule
`default_nettype wire

//--- testbench/lpm_low_power_ctrl_sva.sv
`default_nettype none
module lpm_low_power_ctrl_sva
   import lpm_pkg::*;
#(
   parameter int         REG_START  = REG_START_CYC,
   parameter logic [7:0] SUPPLY_KEY = SC_KEY_DEF
) (
   input wire logic        clk_i, // clock
   input wire logic        rst_i, // sync reset
   input wire logic        wb_cyc_i, // cycle
   input wire logic        wb_stb_i, // strobe
   input wire logic        wb_we_i, // write
   input wire logic [7:0]  wb_adr_i, // address
   input wire logic [3:0]  wb_sel_i, // byte enables
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic        wb_ack_o, // ack
   input wire logic        wfi_i, // wfi pulse
   input wire logic        wfe_i, // wfe pulse
   input wire logic        deep_sleep_select_i, // deep bit
   input wire logic        event_flag_i, // event flag
   input wire logic        irq_i, // interrupt
   input wire lpm_pwr_type pwr_o, // power, clocks
   input wire logic [1:0]  flash_mode_o, // flash state
   input wire logic        core_reset_o, // core reset
   input wire logic [2:0]  mode_o // mode
);
   timeunit 1ns;
   timeprecision 100ps;
   // ******
   // helper logic
   // ******
   logic        take;
   logic        regoff;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign regoff = take && wb_we_i && wb_adr_i == OFS_SUPPLY_CTRL
                   && wb_dat_i[SC_REGOFF_BIT] && wb_sel_i[3] && wb_sel_i[0];
   always_comb next_cnt = (mode_o == 3'h4) ? cnt + 32'h1 : 32'h0;
   always_ff @(posedge clk_i) cnt <= rst_i ? 32'h0 : next_cnt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ******
   // checks
   // ******
   chk_ack_once: assert property (
      take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack pulse");
   chk_key_backup: assert property (
      mode_o == 3'h0 && regoff && wb_dat_i[31:24] == SUPPLY_KEY |=> mode_o == 3'h3 && core_reset_o)
      else $error("no keyed backup");
   chk_bad_key: assert property (
      mode_o == 3'h0 && regoff && wb_dat_i[31:24] != SUPPLY_KEY && !wfi_i && !wfe_i
      |=> mode_o == 3'h0) else $error("bad key obeyed");
   chk_wfe_deep: assert property (
      mode_o == 3'h0 && wfe_i && deep_sleep_select_i && !event_flag_i |=> mode_o == 3'h3)
      else $error("deep wfe missed");
   chk_flag_block: assert property (
      mode_o == 3'h0 && wfe_i && event_flag_i && !wfi_i && !take |=> mode_o == 3'h0)
      else $error("flag ignored");
   chk_sleep_clk: assert property (
      mode_o == 3'h1 |-> !pwr_o.core_clk && pwr_o.mem_clk && pwr_o.core_power)
      else $error("sleep clocks");
   chk_wait_clk: assert property (
      mode_o == 3'h2 |-> !pwr_o.core_clk && !pwr_o.mem_clk && pwr_o.core_power
      && flash_mode_o != 2'h3) else $error("wait state");
   chk_irq_wake: assert property (
      mode_o == 3'h1 && irq_i |=> mode_o == 3'h0) else $error("no irq wake");
   chk_backup_pwr: assert property (
      mode_o == 3'h3 |-> core_reset_o && !pwr_o.regulator_on && pwr_o.reg_out_low
      && !pwr_o.core_power) else $error("backup power");
   chk_reg_start: assert property (
      mode_o == 3'h4 |=> mode_o == ((cnt == 32'(REG_START)) ? 3'h0 : 3'h4))
      else $error("reg start length");
endmodule
bind lpm_low_power_ctrl lpm_low_power_ctrl_sva #(.REG_START(REG_START), .SUPPLY_KEY(SUPPLY_KEY))
   lpm_low_power_ctrl_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wfi_i(wfi_i), .wfe_i(wfe_i),
   .deep_sleep_select_i(deep_sleep_select_i), .event_flag_i(event_flag_i), .irq_i(irq_i),
   .pwr_o(pwr_o), .flash_mode_o(flash_mode_o), .core_reset_o(core_reset_o), .mode_o(mode_o));
`default_nettype wire

//--- testbench/lpm_low_power_ctrl_tb.sv
`default_nettype none
module lpm_low_power_ctrl_tb
   import lpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RS = 8;
   logic          clk_i, rst_i, cyc, stb, we, ack, frc, crst, bkon;
   logic [7:0]    adr;
   logic [3:0]    sel;
   logic [31:0]   dat, rdat, q, pclk;
   logic [1:0]    fl, src, rcf;
   logic [2:0]    mode, pres;
   lpm_pwr_type   pwr;
   int            miscompares, checks_done;
   lpm_core_model core (.clk_i(clk_i), .wfi_o(), .wfe_o(), .deep_o(), .flag_o(), .irq_o(),
      .event_o(), .pins_o(), .alarm_o());
   lpm_low_power_ctrl #(.DEB_CYCLES(2), .REG_START(RS)) lpm_low_power_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
      .wfi_i(core.wfi_o), .wfe_i(core.wfe_o), .deep_sleep_select_i(core.deep_o),
      .event_flag_i(core.flag_o), .irq_i(core.irq_o), .event_i(core.event_o),
      .wakeup_pins_i(core.pins_o), .alarm_i(core.alarm_o), .pwr_o(pwr),
      .periph_clk_en_o(pclk), .flash_mode_o(fl), .mck_src_o(src), .rc_freq_o(rcf),
      .clk_pres_o(pres), .fast_rc_en_o(frc), .core_reset_o(crst), .backup_on_o(bkon),
      .mode_o(mode));
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ******
   // bus and waits
   // ******
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
      int n;
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'h1 && n < 40);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      if (ack !== 1'h1) begin
         miscompares++;
         summarize();
      end
   endtask
   task automatic wait_mode(input logic [2:0] m);
      for (int n = 0; n < 300 && mode !== m; n++) @(posedge clk_i);
      check(32'(mode), 32'(m));
      if (mode !== m) summarize();
   endtask
   // ******
   // scenarios
   // ******
   task automatic s_reset();
      check(32'(pwr), 32'h1E);
      check(32'(fl), 32'h3);
      wb(1'h0, 8'h20, 32'h0);
      check(q, 32'h0);
      wb(1'h1, OFS_PERIPH_CLK, 32'hF3);
      wb(1'h0, OFS_PERIPH_CLK, 32'h0);
      check(q, 32'hF3);
      check(pclk, 32'hF3);
   endtask
   task automatic s_sleep();
      wb(1'h1, OFS_FAST_START, 32'h0);
      core.instr(1'h0);
      wait_mode(3'h1);
      check(32'(pwr), 32'h0E);
      check(pclk, 32'hF3);
      core.irq_o <= 1'h1;
      wait_mode(3'h0);
      core.irq_o <= 1'h0;
      core.flag_o <= 1'h1;
      core.instr(1'h1);
      repeat (3) @(posedge clk_i);
      check(32'(mode), 32'h0);
      core.flag_o <= 1'h0;
      core.instr(1'h1);
      wait_mode(3'h1);
      core.event_o <= 1'h1;
      wait_mode(3'h0);
      core.event_o <= 1'h0;
   endtask
   task automatic s_wait();
      for (int f = 0; f < 3; f++) begin
         wb(1'h1, OFS_MAIN_OSC, 32'h210);
         check(32'(rcf), 32'h1);
         check(32'(pres), 32'h2);
         wb(1'h1, OFS_FAST_START, 32'(f) << 21 | 32'(f == 2) << 20 | 32'h1 << f | 32'h4_0000);
         if (f == 2) core.instr(1'h1);
         else wb(1'h1, OFS_MAIN_OSC, 32'h11);
         wait_mode(3'h2);
         check(32'(fl), 32'(f));
         check(32'(pwr), 32'h06);
         if (f == 1) core.alarm_o.usb <= 1'h1;
         else core.pins_o[f] <= 1'h0;
         wait_mode(3'h0);
         core.alarm_o <= 4'h0;
         core.pins_o <= 16'hFFFF;
         check(32'(rcf), 32'h0);
         check(32'(frc), 32'h1);
         wb(1'h0, OFS_PM_STATUS, 32'h0);
         check(q & 32'h1, 32'h1);
      end
   endtask
   task automatic s_backup();
      int n;
      wb(1'h1, OFS_SUPPLY_CTRL, {~SC_KEY_DEF, 24'h1});
      check(32'(mode), 32'h0);
      wb(1'h1, OFS_SUPPLY_CTRL, {SC_KEY_DEF, 24'h1}, 4'h7);
      check(32'(mode), 32'h0);
      wb(1'h1, OFS_SUPPLY_CTRL, {SC_KEY_DEF, 24'h2});
      check(32'(pwr.regulator_on), 32'h0);
      check(32'(mode), 32'h0);
      wb(1'h1, OFS_SUPPLY_CTRL, {SC_KEY_DEF, 24'h0});
      wb(1'h1, OFS_BACKUP_WAKE, 32'h2_0000);
      wb(1'h1, OFS_SUPPLY_CTRL, {SC_KEY_DEF, 24'h1});
      check(32'(mode), 32'h3);
      check(32'(pwr), 32'h01);
      check(32'({crst, bkon}), 32'h3);
      core.alarm_o.rtc <= 1'h1;
      wait_mode(3'h4);
      core.alarm_o.rtc <= 1'h0;
      n = 0;
      do begin
         n++;
         @(posedge clk_i);
      end while (mode === 3'h4 && n < 50);
      check(32'(n), 32'(RS));
      check(32'(pwr), 32'h1E);
      check(32'({crst, bkon}), 32'h1);
      wb(1'h1, OFS_BACKUP_WAKE, 32'h10_0008);
      core.deep_o <= 1'h1;
      core.instr(1'h1);
      wait_mode(3'h3);
      core.deep_o <= 1'h0;
      core.pins_o[3] <= 1'h0;
      @(posedge clk_i);
      core.pins_o[3] <= 1'h1;
      repeat (5) @(posedge clk_i);
      check(32'(mode), 32'h3);
      core.pins_o[3] <= 1'h0;
      wait_mode(3'h4);
      wait_mode(3'h0);
      core.pins_o[3] <= 1'h1;
   endtask
   initial begin
      clk_i = 1'h0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      rst_i = 1'h1;
      {cyc, stb, we, adr, sel, dat} = '0;
      miscompares = 0;
      checks_done = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      s_reset();
      s_sleep();
      s_wait();
      s_backup();
      summarize();
   end
endmodule
`default_nettype wire
